// >>> verilog/pxcap_pkg.sv
// Package: offsets, field layouts and reset values of the express capability block
package pxcap_pkg;

    // Configuration space byte offsets
    localparam logic [7:0] PXCAP_OFS_IDENT = 8'h70;
    localparam logic [7:0] PXCAP_OFS_NEXT = 8'h71;
    localparam logic [7:0] PXCAP_OFS_CAPWORD = 8'h72;
    localparam logic [7:0] PXCAP_OFS_DEVCAP = 8'h74;
    localparam logic [7:0] PXCAP_OFS_GEN_CTRL = 8'hD4;

    // Fixed identifier and list pointers
    localparam logic [7:0] PXCAP_IDENT_VAL = 8'h10;
    localparam logic [7:0] PXCAP_NEXT_VAL = 8'h00;
    localparam logic [7:0] PXCAP_PREV_NEXT_VAL = 8'h70;

    // Capabilities word fields
    localparam logic [1:0] PXCAP_CW_RSVD = 2'h0;
    localparam logic [4:0] PXCAP_CW_INT_NUM = 5'h00;
    localparam logic PXCAP_CW_SLOT = 1'b0;
    localparam logic [3:0] PXCAP_CW_PORT_KIND = 4'h7;
    localparam logic [3:0] PXCAP_CW_VERSION = 4'h2;
    localparam logic [15:0] PXCAP_CW_RESET = 16'h0072;

    // Device capabilities field positions
    localparam int PXCAP_DC_SCALE_LSB = 26;
    localparam int PXCAP_DC_VALUE_LSB = 18;
    localparam int PXCAP_DC_DEEP_LSB = 9;
    localparam int PXCAP_DC_LIGHT_LSB = 6;
    localparam logic [31:0] PXCAP_DC_RESET = 32'h00008D82;

    // Device capabilities fixed fields
    localparam logic [3:0] PXCAP_DC_RSVD_HI = 4'h0;
    localparam logic [1:0] PXCAP_DC_RSVD_LO = 2'h0;
    localparam logic PXCAP_DC_ROLE_ERR = 1'b1;
    localparam logic [2:0] PXCAP_DC_LAMPS_BUTTON = 3'h0;
    localparam logic PXCAP_DC_WIDE_TAG = 1'b0;
    localparam logic [1:0] PXCAP_DC_GHOST_FN = 2'h0;
    localparam logic [2:0] PXCAP_DC_PAYLOAD = 3'h2;

    // Reset values of hardware-updated fields
    localparam logic [2:0] PXCAP_DEEP_LAT_RESET = 3'h6;
    localparam logic [2:0] PXCAP_LIGHT_LAT_RESET = 3'h6;
    localparam logic [1:0] PXCAP_SCALE_RESET = 2'h0;
    localparam logic [7:0] PXCAP_VALUE_RESET = 8'h00;

    // Multiplier selected by the captured power scale
    typedef enum logic [1:0] {
        PXCAP_SCALE_1_0 = 2'h0,
        PXCAP_SCALE_0_1 = 2'h1,
        PXCAP_SCALE_0_01 = 2'h2,
        PXCAP_SCALE_0_001 = 2'h3
    } pxcap_scale_t;

endpackage : pxcap_pkg

// >>> verilog/pxcap_regs.sv
// Read-only express capability structure with power-limit capture and latency mirrors
`timescale 1ns/10ps

// Contract
// - Capability identifier always reads 10h; writes do nothing.
// - Next-item pointer reads 00h, ending the capability list.
// - Interrupt message number, capabilities bits 13:9, fixed at zero.
// - Slot-implemented bit 8 reads zero permanently.
// - Port kind bits 7:4 return 0111b, express-to-PCI bridge.
// - Capability version bits 3:0 return 2h.
// - Capabilities bits 15:14 read zero.
// - Power-limit message payload bits 9:8 go to device capabilities 27:26.
// - Power-limit message payload bits 7:0 go to device capabilities 25:18.
// - Scale codes 00,01,10,11 select 1.0, 0.1, 0.01, 0.001 multipliers.
// - Device capabilities bit 15 hardwired to one.
// - Device capabilities bits 14, 13, 12 read zero.
// - Deep idle latency bits 11:9 follow general control bits 15:13.
// - Deep idle latency resets to 110b, 32 to 64 us.
// - Light idle latency bits 8:6 follow general control bits 18:16.
// - Light idle latency resets to 110b, 2 to 4 us.
// - Latency fields are raised to the physical layer exit latency on each general control write.
// - Ghost function bits 4:3 read zero; wide tags bit 5 unsupported.
// - Largest payload bits 2:0 encode 010b, 512 bytes.
// - Device capabilities bits 31:28 and 17:16 read zero.
// - Preceding capability's next pointer reads 70h.
module pxcap_regs
    import pxcap_pkg::*;
#(
    parameter int LAT_W = 3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    input wire logic slot_power_msg,
    input wire logic [9:0] slot_power_payload,
    input wire logic gen_ctrl_wr,
    input wire logic [LAT_W-1:0] deep_idle_latency_setting,
    input wire logic [LAT_W-1:0] light_idle_latency_setting,
    input wire logic [LAT_W-1:0] phy_deep_idle_exit_latency,
    input wire logic [LAT_W-1:0] phy_light_idle_exit_latency,
    output logic [1:0] captured_power_scale,
    output logic [7:0] captured_power_value,
    output logic [2:0] deep_idle_exit_latency,
    output logic [2:0] light_idle_exit_latency,
    output logic [7:0] list_entry_pointer
);

    // The latency fields are 3 bits wide in the register layout
    generate
        if (LAT_W != 3) begin : g_bad_width
            $error("pxcap_regs: LAT_W must be 3");
        end
    endgenerate

    logic [1:0] scale_reg, scale_next;
    logic [7:0] value_reg, value_next;
    logic [2:0] deep_reg, deep_next;
    logic [2:0] light_reg, light_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic [7:0] entry_reg, entry_next;
    logic [15:0] cap_word;
    logic [31:0] dev_cap;

    // Capabilities word assembled from constants only
    always_comb begin
        cap_word[15:14] = PXCAP_CW_RSVD;
        cap_word[13:9] = PXCAP_CW_INT_NUM;
        cap_word[8] = PXCAP_CW_SLOT;
        cap_word[7:4] = PXCAP_CW_PORT_KIND;
        cap_word[3:0] = PXCAP_CW_VERSION;
    end

    // Device capabilities word: constants plus the four live fields
    always_comb begin
        dev_cap[31:28] = PXCAP_DC_RSVD_HI;
        dev_cap[27:26] = scale_reg;
        dev_cap[25:18] = value_reg;
        dev_cap[17:16] = PXCAP_DC_RSVD_LO;
        dev_cap[15] = PXCAP_DC_ROLE_ERR;
        dev_cap[14:12] = PXCAP_DC_LAMPS_BUTTON;
        dev_cap[11:9] = deep_reg;
        dev_cap[8:6] = light_reg;
        // no wide tags, no ghost functions
        dev_cap[5] = PXCAP_DC_WIDE_TAG;
        dev_cap[4:3] = PXCAP_DC_GHOST_FN;
        dev_cap[2:0] = PXCAP_DC_PAYLOAD;
    end

    // Hardware-updated fields; config writes never reach them
    always_comb begin
        scale_next = scale_reg;
        value_next = value_reg;
        deep_next = deep_reg;
        light_next = light_reg;
        if (slot_power_msg) begin
            scale_next = slot_power_payload[9:8];
        end
        if (slot_power_msg) begin
            value_next = slot_power_payload[7:0];
        end
        // deep idle mirror, floored at the PHY latency
        if (gen_ctrl_wr) begin
            if (deep_idle_latency_setting < phy_deep_idle_exit_latency) begin
                deep_next = phy_deep_idle_exit_latency;
            end else begin
                deep_next = deep_idle_latency_setting;
            end
        end
        // light idle mirror, floored at the PHY latency
        if (gen_ctrl_wr) begin
            if (light_idle_latency_setting < phy_light_idle_exit_latency) begin
                light_next = phy_light_idle_exit_latency;
            end else begin
                light_next = light_idle_latency_setting;
            end
        end
    end

    // Field registers
    always_ff @(posedge clock) begin
        if (rst) begin
            scale_reg <= PXCAP_SCALE_RESET;
            value_reg <= PXCAP_VALUE_RESET;
            deep_reg <= PXCAP_DEEP_LAT_RESET;
            light_reg <= PXCAP_LIGHT_LAT_RESET;
        end else begin
            scale_reg <= scale_next;
            value_reg <= value_next;
            deep_reg <= deep_next;
            light_reg <= light_next;
        end
    end

    // Config read decode; unmapped dwords return zero so an outer mux can OR them
    always_comb begin
        rdata_next = 32'h00000000;
        ack_next = cfg_rd | cfg_wr;
        if (cfg_rd && cfg_addr[7:2] == PXCAP_OFS_IDENT[7:2]) begin
            rdata_next = {cap_word, PXCAP_NEXT_VAL, PXCAP_IDENT_VAL};
        end else if (cfg_rd && cfg_addr[7:2] == PXCAP_OFS_DEVCAP[7:2]) begin
            rdata_next = dev_cap;
        end
        // pointer that the previous capability presents
        entry_next = PXCAP_PREV_NEXT_VAL;
    end

    // Bus answer registers; ack is a one-cycle pulse per request cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_reg <= 32'h00000000;
            ack_reg <= 1'b0;
            entry_reg <= PXCAP_PREV_NEXT_VAL;
        end else begin
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            entry_reg <= entry_next;
        end
    end

    assign cfg_rdata = rdata_reg;
    assign cfg_ack = ack_reg;
    assign captured_power_scale = scale_reg;
    assign captured_power_value = value_reg;
    assign deep_idle_exit_latency = deep_reg;
    assign light_idle_exit_latency = light_reg;
    assign list_entry_pointer = entry_reg;

    // Checks: all in the one clock domain
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_read_ident;
        cfg_rd && cfg_addr[7:2] == 6'h1C;
    endsequence

    sequence s_read_devcap;
        cfg_rd && cfg_addr[7:2] == 6'h1D;
    endsequence

    sequence s_quiet;
        !slot_power_msg && !gen_ctrl_wr;
    endsequence

    chk_ident_word: assert property (
        s_read_ident |=> cfg_ack && cfg_rdata[15:0] == 16'h0010)
        else $error("identifier or next pointer wrong");

    chk_cap_word: assert property (
        s_read_ident |=> cfg_rdata[31:16] == 16'h0072)
        else $error("capabilities word wrong");

    chk_devcap_fixed: assert property (
        s_read_devcap |=> cfg_rdata[31:28] == 4'h0 && cfg_rdata[17:12] == 6'h08
            && cfg_rdata[5:0] == 6'h02)
        else $error("device capabilities constants wrong");

    // Capture at the message edge, still held two quiet cycles later
    chk_scale_capture: assert property (
        slot_power_msg ##1 !slot_power_msg [*2]
            |-> captured_power_scale == $past(slot_power_payload[9:8], 2))
        else $error("power scale not captured");

    chk_value_capture: assert property (
        slot_power_msg |=> captured_power_value == $past(slot_power_payload[7:0]))
        else $error("power value not captured");

    chk_deep_floor: assert property (
        gen_ctrl_wr |=> deep_idle_exit_latency >= $past(phy_deep_idle_exit_latency)
            && light_idle_exit_latency >= $past(phy_light_idle_exit_latency))
        else $error("latency below physical exit latency");

    chk_light_follow: assert property (
        gen_ctrl_wr && light_idle_latency_setting >= phy_light_idle_exit_latency
            |=> light_idle_exit_latency == $past(light_idle_latency_setting))
        else $error("light idle latency not mirrored");

    chk_write_inert: assert property (
        cfg_wr && !cfg_rd ##0 s_quiet |=> cfg_ack && cfg_rdata == 32'h00000000
            && $stable(captured_power_value) && $stable(deep_idle_exit_latency))
        else $error("config write altered state");

    chk_reset_values: assert property (
        $fell(rst) |-> captured_power_scale == 2'h0 && captured_power_value == 8'h00
            && deep_idle_exit_latency == 3'h6 && light_idle_exit_latency == 3'h6)
        else $error("reset values wrong");

    chk_entry_ptr: assert property (
        cfg_rd |-> ##[1:2] list_entry_pointer == 8'h70)
        else $error("list entry pointer wrong");

    sequence s_any_request;
        cfg_rd || cfg_wr;
    endsequence

    chk_ack_follows: assert property (
        s_any_request |=> cfg_ack)
        else $error("request not acknowledged");

    chk_ack_idle: assert property (
        !cfg_rd && !cfg_wr |=> !cfg_ack)
        else $error("acknowledge without request");

    chk_next_pointer: assert property (
        s_read_ident |=> cfg_rdata[15:8] == 8'h00)
        else $error("next pointer not zero");

    chk_int_number: assert property (
        s_read_ident |=> cfg_rdata[29:25] == 5'h00)
        else $error("interrupt message number not zero");

    chk_no_slot: assert property (
        s_read_ident |=> !cfg_rdata[24])
        else $error("slot bit set");

    chk_cap_version: assert property (
        s_read_ident |=> cfg_rdata[19:16] == 4'h2)
        else $error("capability version wrong");

    chk_cap_reserved: assert property (
        s_read_ident |=> cfg_rdata[31:30] == 2'h0)
        else $error("capabilities reserved bits set");

    chk_no_lamps: assert property (
        s_read_devcap |=> cfg_rdata[14:12] == 3'h0)
        else $error("lamp or button bit set");

    chk_ghost_tags: assert property (
        s_read_devcap |=> cfg_rdata[5:3] == 3'h0)
        else $error("ghost function or wide tag bits set");

    // Read data must show the live fields as they stood at the request edge
    chk_devcap_live: assert property (
        s_read_devcap |=> cfg_rdata[27:18] == $past({captured_power_scale, captured_power_value})
            && cfg_rdata[11:6] == $past({deep_idle_exit_latency, light_idle_exit_latency}))
        else $error("live fields not shown in read data");

    // Without a message or a control write nothing may move
    chk_fields_hold: assert property (
        s_quiet |=> $stable(captured_power_scale) && $stable(captured_power_value)
            && $stable(deep_idle_exit_latency) && $stable(light_idle_exit_latency))
        else $error("hardware field changed without an event");

endmodule : pxcap_regs

// >>> sim/pxcap_host_model.sv
// Host model: config requests and power-limit messages toward the capability block
`timescale 1ns/10ps
module pxcap_host_model (
    input wire logic clock,
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack,
    output logic slot_power_msg,
    output logic [9:0] slot_power_payload
);
    // Idle bus from time zero
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        slot_power_msg = 1'b0;
        slot_power_payload = 10'h000;
    end

    // Request held up to the edge that sees the ack; the released address shows the inverse
    task automatic cfg_access(input logic wr, input logic [7:0] a, output logic [31:0] d,
                              output bit ok);
        ok = 1'b0;
        d = 32'hFFFFFFFF;
        @(posedge clock);
        cfg_rd <= !wr;
        cfg_wr <= wr;
        cfg_addr <= a;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge clock);
            if (cfg_ack === 1'b1) begin
                ok = 1'b1;
                d = cfg_rdata;
            end
        end
        // The ack edge takes the request once more; repeating it is harmless
        cfg_rd <= 1'b0;
        cfg_wr <= 1'b0;
        cfg_addr <= ~a;
    endtask : cfg_access

    task automatic send_limit(input logic [9:0] p);
        @(posedge clock);
        slot_power_msg <= 1'b1;
        slot_power_payload <= p;
        @(posedge clock);
        slot_power_msg <= 1'b0;
        slot_power_payload <= ~p;
    endtask : send_limit

    // limit is value times the scale multiplier, in milliwatts
    function automatic int limit_mw(input logic [1:0] s, input logic [7:0] v);
        int k;
        k = int'(v) * 1000;
        repeat (s) k = k / 10;
        return k;
    endfunction : limit_mw
endmodule : pxcap_host_model

// >>> sim/tb.sv
// Self-checking bench for the express capability register block
`timescale 1ns/10ps
module tb;
    import pxcap_pkg::*;
    logic clock, rst, cfg_rd, cfg_wr, cfg_ack, slot_power_msg, gen_ctrl_wr;
    logic [7:0] cfg_addr, captured_power_value, list_entry_pointer;
    logic [31:0] cfg_rdata;
    logic [9:0] slot_power_payload;
    logic [2:0] deep_set, light_set, phy_deep, phy_light, deep_lat, light_lat;
    logic [1:0] captured_power_scale;
    int bad_count = 0;
    int checked = 0;
    typedef struct {
        logic [9:0] pay;
        logic [2:0] deep, pdeep, light, plight, edeep, elight;
        int mw;
    } pxcap_row_t;
    // Every scale code once; settings below the floor must be raised to it
    pxcap_row_t rows [4] = '{
        '{10'h0A5, 3'h3, 3'h1, 3'h5, 3'h2, 3'h3, 3'h5, 165000},
        '{10'h1FF, 3'h2, 3'h4, 3'h7, 3'h1, 3'h4, 3'h7, 25500},
        '{10'h2C8, 3'h0, 3'h0, 3'h1, 3'h3, 3'h0, 3'h3, 2000},
        '{10'h37E, 3'h7, 3'h7, 3'h6, 3'h6, 3'h7, 3'h6, 126}};

    pxcap_regs i_dut (.clock(clock), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .slot_power_msg(slot_power_msg), .slot_power_payload(slot_power_payload),
        .gen_ctrl_wr(gen_ctrl_wr), .deep_idle_latency_setting(deep_set),
        .light_idle_latency_setting(light_set), .phy_deep_idle_exit_latency(phy_deep),
        .phy_light_idle_exit_latency(phy_light), .captured_power_scale(captured_power_scale),
        .captured_power_value(captured_power_value), .deep_idle_exit_latency(deep_lat),
        .light_idle_exit_latency(light_lat), .list_entry_pointer(list_entry_pointer));

    pxcap_host_model i_host (.clock(clock), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .slot_power_msg(slot_power_msg), .slot_power_payload(slot_power_payload));

    // 100 ns period
    always #50 clock = ~clock;

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // A missing acknowledge counts as a mismatch and ends the run
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bit ok;
        i_host.cfg_access(wr, a, d, ok);
        if (!ok) begin
            bad_count++;
            give_verdict();
        end else check(d, exp);
    endtask : access

    function automatic logic [31:0] devcap(input logic [9:0] p, input logic [2:0] d, l);
        return {4'h0, p[9:8], p[7:0], 2'h0, 1'b1, 3'h0, d, l, 1'b0, 2'h0, 3'h2};
    endfunction : devcap

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        gen_ctrl_wr = 1'b0;
        deep_set = 3'h0;
        light_set = 3'h0;
        phy_deep = 3'h0;
        phy_light = 3'h0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        access(1'b0, PXCAP_OFS_IDENT, 32'h00720010);
        access(1'b0, PXCAP_OFS_DEVCAP, 32'h00008D82);
        check({24'h0, list_entry_pointer}, 32'h00000070);
        access(1'b1, PXCAP_OFS_IDENT, 32'h00000000);
        access(1'b0, PXCAP_OFS_IDENT, 32'h00720010);
        access(1'b0, 8'h78, 32'h00000000);
        // Table of latency settings and power messages
        foreach (rows[i]) begin
            @(posedge clock);
            gen_ctrl_wr <= 1'b1;
            deep_set <= rows[i].deep;
            light_set <= rows[i].light;
            phy_deep <= rows[i].pdeep;
            phy_light <= rows[i].plight;
            @(posedge clock);
            gen_ctrl_wr <= 1'b0;
            i_host.send_limit(rows[i].pay);
            access(1'b0, PXCAP_OFS_DEVCAP,
                   devcap(rows[i].pay, rows[i].edeep, rows[i].elight));
            check({30'h0, captured_power_scale}, {30'h0, rows[i].pay[9:8]});
            check({24'h0, captured_power_value}, {24'h0, rows[i].pay[7:0]});
            check({29'h0, deep_lat}, {29'h0, rows[i].edeep});
            check({29'h0, light_lat}, {29'h0, rows[i].elight});
            check(32'(i_host.limit_mw(captured_power_scale, captured_power_value)),
                  32'(rows[i].mw));
        end
        // Write to the captured word must leave the last capture intact
        access(1'b1, PXCAP_OFS_DEVCAP, 32'h00000000);
        access(1'b0, PXCAP_OFS_DEVCAP, devcap(10'h37E, 3'h7, 3'h6));
        // Message, control write and config write together: only the config write is inert
        fork
            i_host.send_limit(10'h1A5);
            access(1'b1, PXCAP_OFS_DEVCAP, 32'h00000000);
            begin
                @(posedge clock);
                gen_ctrl_wr <= 1'b1;
                deep_set <= 3'h5;
                light_set <= 3'h4;
                phy_deep <= 3'h0;
                phy_light <= 3'h0;
                @(posedge clock);
                gen_ctrl_wr <= 1'b0;
            end
        join
        access(1'b0, PXCAP_OFS_DEVCAP, devcap(10'h1A5, 3'h5, 3'h4));
        // Mid-run reset returns captures to zero and latencies to their defaults
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        access(1'b0, PXCAP_OFS_DEVCAP, 32'h00008D82);
        give_verdict();
    end
endmodule : tb
